// file: design/stp_translate.sv
module stp_translate (
    input wire logic clk,                                      // System clock.
    input wire logic nrst,                                     // Asynchronous reset, low.
    input wire logic ce,                                       // Clock enable.
    input wire logic cycleValid,                               // Cycle presented this clock.
    input wire stp_pkg::stp_cycle_t cycleIn,                   // Code, address, strobes.
    input wire logic descLoad,                                 // Write one segment slot.
    input wire logic [stp_pkg::SEG_IDX_W-1:0] descIndex,       // Slot to write.
    input wire stp_pkg::stp_desc_t descData,                   // Segment definition.
    input wire logic tableLoad,                                // Write one space table entry.
    input wire logic [stp_pkg::CODE_W-1:0] tableCode,          // Entry to write.
    input wire logic [stp_pkg::TASK_W-1:0] tableTask,          // Task number for entry.
    output logic physValid,                                    // Mapped address valid pulse.
    output stp_pkg::stp_phys_t physOut,                        // Mapped address and strobes.
    output logic segmentFault,                                 // Undefined segment pulse.
    output logic writeViolation,                               // Write to protected pulse.
    output logic segmentIrq,                                   // Watched segment hit pulse.
    output logic [stp_pkg::SEG_IDX_W-1:0] hitSegment,          // Last matched slot.
    output logic directDone,                                   // Direct translation pulse.
    output logic directHit,                                    // Direct address matched.
    output logic [stp_pkg::LOG_W-1:0] directAddr               // Direct translation result.
);

    // ========================================================================
    // State
    // ========================================================================
    stp_pkg::stp_desc_t descReg [stp_pkg::SEG_COUNT];
    stp_pkg::stp_desc_t descNext [stp_pkg::SEG_COUNT];
    logic [stp_pkg::TASK_W-1:0] tableReg [stp_pkg::CODE_COUNT];
    logic [stp_pkg::TASK_W-1:0] tableNext [stp_pkg::CODE_COUNT];

    logic physValid_reg;
    logic physValid_next;
    stp_pkg::stp_phys_t phys_reg;
    stp_pkg::stp_phys_t phys_next;
    logic fault_reg;
    logic fault_next;
    logic violation_reg;
    logic violation_next;
    logic irq_reg;
    logic irq_next;
    logic [stp_pkg::SEG_IDX_W-1:0] hitSeg_reg;
    logic [stp_pkg::SEG_IDX_W-1:0] hitSeg_next;
    logic directDone_reg;
    logic directDone_next;
    logic directHit_reg;
    logic directHit_next;
    logic [stp_pkg::LOG_W-1:0] directAddr_reg;
    logic [stp_pkg::LOG_W-1:0] directAddr_next;

    // ========================================================================
    // Cycle classification
    // ========================================================================
    logic isSuper;
    logic isProgram;
    logic isData;
    logic [stp_pkg::TASK_W-1:0] cycleTask;
    logic [stp_pkg::MAP_W-1:0] mappedPart;

    always_comb begin
        // The full four-bit code indexes the table, so a second master gets
        // its own eight entries when the fourth bit is high.
        cycleTask = tableReg[cycleIn.code];
        isSuper = cycleIn.code[stp_pkg::CODE_SUPER_BIT];
        isProgram = (cycleIn.code[2:0] == stp_pkg::CODE_USER_PROG) ||
                    (cycleIn.code[2:0] == stp_pkg::CODE_SUPER_PROG);
        isData = (cycleIn.code[2:0] == stp_pkg::CODE_USER_DATA) ||
                 (cycleIn.code[2:0] == stp_pkg::CODE_SUPER_DATA);
        mappedPart = cycleIn.logicalAddr[stp_pkg::MAP_MSB:stp_pkg::MAP_LSB];
    end

    // ========================================================================
    // Segment match
    // ========================================================================
    logic [stp_pkg::SEG_COUNT-1:0] segHit;

    // CPU space and undefined codes carry no program or data attribute, so
    // only the privilege attribute restricts them.
    generate
        for (genvar g = 0; g < stp_pkg::SEG_COUNT; g++) begin : gSeg
            logic addrOk;
            logic taskOk;
            logic typeOk;
            always_comb begin
                addrOk = ((mappedPart ^ descReg[g].logicalBase) &
                          descReg[g].logicalMask) == '0;
                taskOk = ((cycleTask ^ descReg[g].taskSpaceNumber) &
                          descReg[g].taskSpaceMask) == '0;
                typeOk = (isSuper ? descReg[g].allowSuper : descReg[g].allowUser) &&
                         (!isProgram || descReg[g].allowProgram) &&
                         (!isData || descReg[g].allowData);
                segHit[g] = descReg[g].valid && addrOk && taskOk && typeOk;
            end
        end
    endgenerate

    logic anyHit;
    logic [stp_pkg::SEG_IDX_W-1:0] hitIdx;
    stp_pkg::stp_desc_t hitDesc;
    logic [stp_pkg::MAP_W-1:0] physHigh;
    logic [stp_pkg::LOG_W-1:0] physFull;

    always_comb begin
        anyHit = 1'b0;
        hitIdx = stp_pkg::SEG_IDX_RESET;
        // Descending scan so the lowest matching slot wins on overlap.
        for (int i = stp_pkg::SEG_COUNT - 1; i >= 0; i--) begin
            if (segHit[i]) begin
                anyHit = 1'b1;
                hitIdx = stp_pkg::SEG_IDX_W'(i);
            end
        end
        hitDesc = descReg[hitIdx];
        physHigh = (hitDesc.physicalBase & hitDesc.logicalMask) |
                   (mappedPart & ~hitDesc.logicalMask);
        physFull = {physHigh, cycleIn.logicalAddr[stp_pkg::PASS_W-1:0]};
    end

    // ========================================================================
    // Table next values
    // ========================================================================
    // A load in the same clock as a cycle takes effect after that cycle,
    // so a cycle always sees one consistent set of definitions.
    always_comb begin
        for (int i = 0; i < stp_pkg::SEG_COUNT; i++) begin
            descNext[i] = descReg[i];
        end
        for (int i = 0; i < stp_pkg::CODE_COUNT; i++) begin
            tableNext[i] = tableReg[i];
        end
        if (descLoad) begin
            descNext[descIndex] = descData;
        end
        if (tableLoad) begin
            tableNext[tableCode] = tableTask;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < stp_pkg::SEG_COUNT; i++) begin
                descReg[i] <= stp_pkg::DESC_RESET;
            end
            for (int i = 0; i < stp_pkg::CODE_COUNT; i++) begin
                tableReg[i] <= stp_pkg::TASK_RESET;
            end
        end else if (ce) begin
            for (int i = 0; i < stp_pkg::SEG_COUNT; i++) begin
                descReg[i] <= descNext[i];
            end
            for (int i = 0; i < stp_pkg::CODE_COUNT; i++) begin
                tableReg[i] <= tableNext[i];
            end
        end
    end

    // ========================================================================
    // Result next values
    // ========================================================================
    logic normalCycle;
    logic directCycle;
    logic violates;

    always_comb begin
        normalCycle = cycleValid && !cycleIn.direct;
        directCycle = cycleValid && cycleIn.direct;
        violates = anyHit && hitDesc.writeProtect && !cycleIn.isRead;

        physValid_next = normalCycle && anyHit && !violates;
        fault_next = normalCycle && !anyHit;
        violation_next = normalCycle && violates;
        irq_next = normalCycle && anyHit && hitDesc.irqEnable;
        directDone_next = directCycle;
        directHit_next = directCycle && anyHit;

        phys_next = phys_reg;
        hitSeg_next = hitSeg_reg;
        directAddr_next = directAddr_reg;
        if (normalCycle && anyHit && !violates) begin
            phys_next.physicalAddr = physFull;
            phys_next.strobes = cycleIn.strobes;
        end
        if (cycleValid && anyHit) begin
            hitSeg_next = hitIdx;
        end
        if (directCycle) begin
            // Unmatched direct requests return zero rather than a stale value.
            directAddr_next = anyHit ? physFull : stp_pkg::ADDR_RESET;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            physValid_reg <= 1'b0;
            phys_reg <= stp_pkg::PHYS_RESET;
            fault_reg <= 1'b0;
            violation_reg <= 1'b0;
            irq_reg <= 1'b0;
            hitSeg_reg <= stp_pkg::SEG_IDX_RESET;
            directDone_reg <= 1'b0;
            directHit_reg <= 1'b0;
            directAddr_reg <= stp_pkg::ADDR_RESET;
        end else if (ce) begin
            physValid_reg <= physValid_next;
            phys_reg <= phys_next;
            fault_reg <= fault_next;
            violation_reg <= violation_next;
            irq_reg <= irq_next;
            hitSeg_reg <= hitSeg_next;
            directDone_reg <= directDone_next;
            directHit_reg <= directHit_next;
            directAddr_reg <= directAddr_next;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign physValid = physValid_reg;
    assign physOut = phys_reg;
    assign segmentFault = fault_reg;
    assign writeViolation = violation_reg;
    assign segmentIrq = irq_reg;
    assign hitSegment = hitSeg_reg;
    assign directDone = directDone_reg;
    assign directHit = directHit_reg;
    assign directAddr = directAddr_reg;

endmodule

// file: design/stp_pkg.sv
package stp_pkg;

    // ========================================================================
    // Sizes
    // ========================================================================
    localparam int SEG_COUNT = 32;
    localparam int SEG_IDX_W = 5;
    localparam int CODE_W = 4;
    localparam int CODE_COUNT = 16;
    localparam int LOG_W = 23;
    localparam int MAP_W = 16;
    localparam int PASS_W = 7;
    localparam int MAP_LSB = 7;
    localparam int MAP_MSB = 22;
    localparam int TASK_W = 8;
    localparam int STROBE_W = 2;

    // ========================================================================
    // Cycle type codes, low three bits
    // ========================================================================
    localparam int CODE_SUPER_BIT = 2;
    localparam logic [2:0] CODE_USER_DATA = 3'h1;
    localparam logic [2:0] CODE_USER_PROG = 3'h2;
    localparam logic [2:0] CODE_SUPER_DATA = 3'h5;
    localparam logic [2:0] CODE_SUPER_PROG = 3'h6;
    localparam logic [2:0] CODE_CPU_SPACE = 3'h7;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [TASK_W-1:0] TASK_RESET = 8'h00;
    localparam logic [SEG_IDX_W-1:0] SEG_IDX_RESET = 5'h00;
    localparam logic [LOG_W-1:0] ADDR_RESET = 23'h00_0000;

    // ========================================================================
    // Carriers
    // ========================================================================
    typedef struct packed {
        logic valid;
        logic writeProtect;
        logic irqEnable;
        logic allowUser;
        logic allowSuper;
        logic allowProgram;
        logic allowData;
        logic [TASK_W-1:0] taskSpaceNumber;
        logic [TASK_W-1:0] taskSpaceMask;
        logic [MAP_W-1:0] logicalBase;
        logic [MAP_W-1:0] logicalMask;
        logic [MAP_W-1:0] physicalBase;
    } stp_desc_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [LOG_W-1:0] logicalAddr;
        logic [STROBE_W-1:0] strobes;
        logic isRead;
        logic direct;
    } stp_cycle_t;

    typedef struct packed {
        logic [LOG_W-1:0] physicalAddr;
        logic [STROBE_W-1:0] strobes;
    } stp_phys_t;

    localparam stp_desc_t DESC_RESET = '0;
    localparam stp_phys_t PHYS_RESET = '0;

endpackage

// file: test/stp_translate_props.sv
// ==========
// Timing checks at the translator boundary
module stp_translate_props (
    input wire logic clk, // System clock.
    input wire logic nrst, // Reset, low.
    input wire logic ce, // Clock enable.
    input wire logic cycleValid, // Cycle strobe.
    input wire stp_pkg::stp_cycle_t cycleIn, // Presented cycle.
    input wire logic physValid, // Mapped pulse.
    input wire stp_pkg::stp_phys_t physOut, // Mapped address.
    input wire logic segmentFault, // Fault pulse.
    input wire logic writeViolation, // Violation pulse.
    input wire logic segmentIrq, // Watch pulse.
    input wire logic directDone, // Direct pulse.
    input wire logic directHit, // Direct match.
    input wire logic [stp_pkg::LOG_W-1:0] directAddr // Direct result.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_normal;
        ce && cycleValid && !cycleIn.direct;
    endsequence
    sequence s_direct;
        ce && cycleValid && cycleIn.direct;
    endsequence
    property p_answer; s_normal |=> $onehot({physValid, segmentFault, writeViolation}); endproperty
    a_answer: assert property (p_answer) else $error("normal cycle answer count wrong");
    property p_pass; s_normal ##1 physValid |-> physOut.strobes == $past(cycleIn.strobes)
        && physOut.physicalAddr[6:0] == $past(cycleIn.logicalAddr[6:0]); endproperty
    a_pass: assert property (p_pass) else $error("low address bits not passed through");
    property p_read; s_normal ##0 cycleIn.isRead |=> !writeViolation; endproperty
    a_read: assert property (p_read) else $error("read cycle flagged as violation");
    property p_block; segmentFault || writeViolation |-> !physValid && $stable(physOut); endproperty
    a_block: assert property (p_block) else $error("refused cycle shows a mapped address");
    property p_hold; $changed(physOut) |-> physValid; endproperty
    a_hold: assert property (p_hold) else $error("mapped address moved without a pulse");
    property p_direct; s_direct |=> directDone
        && !(physValid || segmentFault || writeViolation || segmentIrq); endproperty
    a_direct: assert property (p_direct) else $error("direct request answered wrongly");
    property p_irq; segmentIrq |-> physValid || writeViolation; endproperty
    a_irq: assert property (p_irq) else $error("watch pulse without a matched cycle");
    property p_miss; directDone && !directHit |-> directAddr == '0; endproperty
    a_miss: assert property (p_miss) else $error("direct miss left a nonzero result");
endmodule

bind stp_translate stp_translate_props i_props (.clk, .nrst, .ce, .cycleValid, .cycleIn,
    .physValid, .physOut, .segmentFault, .writeViolation, .segmentIrq, .directDone,
    .directHit, .directAddr);

// file: test/stp_master.sv
// ==========
// Bus master that presents one cycle per request
module stp_master #(parameter bit SINGLE = 1'b0) (
    input wire logic clk, // System clock.
    input wire logic issue, // Present a cycle.
    input wire stp_pkg::stp_cycle_t cyc, // Cycle to present.
    output logic cycleValid, // Cycle strobe.
    output stp_pkg::stp_cycle_t cycleIn // Presented cycle.
);
    timeunit 1ns;
    timeprecision 1ps;
    stp_pkg::stp_cycle_t lastReg = '0;
    stp_pkg::stp_cycle_t shown;
    always_comb begin
        shown = cyc;
        if (SINGLE) shown.code[3] = 1'b0;
    end
    always @(posedge clk) if (issue) lastReg <= shown;
    // Between cycles the bus shows the inverse so stale values never look valid.
    assign cycleValid = issue;
    assign cycleIn = issue ? shown : ~lastReg;
endmodule

// file: test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Stimulus, outputs and reference state
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b0;
    logic issue = 1'b0;
    logic descLoad = 1'b0;
    logic tableLoad = 1'b0;
    logic [4:0] descIndex = 5'h00;
    logic [3:0] tableCode = 4'h0;
    logic [7:0] tableTask = 8'h00;
    stp_pkg::stp_cycle_t cyc = '0;
    stp_pkg::stp_desc_t descData = '0;
    stp_pkg::stp_cycle_t cycleIn;
    stp_pkg::stp_phys_t physOut, ePhys;
    logic cycleValid, physValid, segmentFault, writeViolation, segmentIrq, directDone, directHit;
    logic ePv, eFlt, eWv, eIrq, eDd, eDh;
    logic [4:0] hitSegment, eHit;
    logic [22:0] directAddr, eAddr;
    stp_pkg::stp_desc_t mDesc [32] = '{default: '0};
    logic [7:0] mTable [16] = '{default: '0};
    int nErrors = 0;
    int checks = 0;
    integer seed = 32'haea5_46d6;

    stp_master #(.SINGLE(1'b0)) i_master (.clk, .issue, .cyc, .cycleValid, .cycleIn);
    stp_translate i_dut (.clk, .nrst, .ce, .cycleValid, .cycleIn, .descLoad, .descIndex,
        .descData, .tableLoad, .tableCode, .tableTask, .physValid, .physOut, .segmentFault,
        .writeViolation, .segmentIrq, .hitSegment, .directDone, .directHit, .directAddr);

    initial forever #10 clk = ~clk;

    task automatic final_report();
        if (nErrors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL %s expected %h got %h", name, exp, got);
        end
    endtask

    // Lowest matching slot wins; privilege and reference kind come from the code.
    function automatic int slot_of(stp_pkg::stp_cycle_t c);
        stp_pkg::stp_desc_t d;
        logic [2:0] t;
        t = c.code[2:0];
        for (int i = 0; i < 32; i++) begin
            d = mDesc[i];
            if (d.valid && ((c.logicalAddr[22:7] ^ d.logicalBase) & d.logicalMask) == 16'h0000
                && ((mTable[c.code] ^ d.taskSpaceNumber) & d.taskSpaceMask) == 8'h00
                && (c.code[2] ? d.allowSuper : d.allowUser)
                && (t == 3'h2 || t == 3'h6 ? d.allowProgram : 1'b1)
                && (t == 3'h1 || t == 3'h5 ? d.allowData : 1'b1)) return i;
        end
        return -1;
    endfunction

    function automatic logic [22:0] mapped(stp_pkg::stp_cycle_t c, stp_pkg::stp_desc_t d);
        return {(d.physicalBase & d.logicalMask) | (c.logicalAddr[22:7] & ~d.logicalMask),
            c.logicalAddr[6:0]};
    endfunction

    initial begin
        #200000;
        nErrors++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic [95:0] w;
        int s;
        stp_pkg::stp_cycle_t c;
        {ePv, eFlt, eWv, eIrq, eDd, eDh, eHit, eAddr, ePhys} = '0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            chk("physValid", ePv, physValid);
            chk("segmentFault", eFlt, segmentFault);
            chk("writeViolation", eWv, writeViolation);
            chk("segmentIrq", eIrq, segmentIrq);
            chk("directDone", eDd, directDone);
            if (eDd) chk("directHit", eDh, directHit);
            chk("directAddr", eAddr, directAddr);
            chk("physOut", ePhys, physOut);
            chk("hitSegment", eHit, hitSegment);
            r = $random(seed);
            w = {$random(seed), $random(seed), $random(seed)};
            c = w[30:0];
            s = r[9:5];
            if (r[11]) c.logicalAddr[22:7] = (mDesc[s].logicalBase & mDesc[s].logicalMask)
                | (c.logicalAddr[22:7] & ~mDesc[s].logicalMask);
            c.direct = r[12:10] == 3'h0;
            descData = w[95:25];
            descData.logicalMask = 16'hffff << (r[20:16] % 17);
            descData.taskSpaceMask &= 8'h03;
            {ce, issue} = {r[23:21] != 3'h0, r[25:24] != 2'h0};
            {descLoad, tableLoad} = {r[28:26] == 3'h0, r[31:29] == 3'h0};
            {descIndex, tableCode, tableTask} = {r[4:0], r[3:0], w[7:0]};
            if (i < 32) begin
                {ce, issue, descLoad, tableLoad} = 4'hb;
                {descIndex, tableCode} = {i[4:0], i[3:0]};
            end else if (i < 64) begin
                {ce, issue, c.direct} = 3'h6;
                c.code = i[3:0];
            end
            if (ce) begin
                {ePv, eFlt, eWv, eIrq, eDd} = '0;
                s = issue ? slot_of(c) : -1;
                if (s >= 0) eHit = s[4:0];
                if (issue && c.direct) begin
                    eDd = 1'b1;
                    eDh = s >= 0;
                    eAddr = eDh ? mapped(c, mDesc[s]) : '0;
                end else if (issue && s < 0) begin
                    eFlt = 1'b1;
                end else if (issue) begin
                    eIrq = mDesc[s].irqEnable;
                    eWv = !c.isRead && mDesc[s].writeProtect;
                    ePv = !eWv;
                    if (ePv) ePhys = {mapped(c, mDesc[s]), c.strobes};
                end
                if (descLoad) mDesc[descIndex] = descData;
                if (tableLoad) mTable[tableCode] = tableTask;
            end
            cyc = c;
        end
        final_report();
    end
endmodule
